// *** verification/spm_far_model.sv ***
/*
 Far-side model: source word memory and a stalling character sink.
 Assumes the mover's registered strobes and a single clock.
*/
`timescale 1ns/100ps
module spm_far_model (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic src_rd,
    input wire logic [15:0] src_addr,
    output logic [15:0] src_rdata,
    input wire logic [7:0] tx_char,
    input wire logic tx_valid,
    output logic tx_ready
);
    logic [7:0] got[$];
    // Word answered after the strobe, scrambled when not held
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            src_rdata <= 16'h0000;
        else if (src_rd)
            src_rdata <= {src_addr[7:0], 8'h29};
        else
            src_rdata <= ~src_rdata;
    end
    // Sink stalls every other cycle and records taken characters
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            tx_ready <= 1'b0;
        else
            tx_ready <= !tx_ready;
        if (arst_n && tx_valid && tx_ready)
            got.push_back(tx_char);
    end
endmodule // spm_far_model

// *** verification/spm_mover_tb.sv ***
/*
 Self-checking bench for the byte mover.
 Assumes registered outputs and inputs driven at the falling edge.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t mismatch %h vs %h", $time, a, b); end end
module spm_mover_tb;
    import spm_pkg::*;
    logic clock = 0, arst_n = 0, start_rx = 0, start_tx = 0, board_fitted = 1;
    logic [15:0] ctrl_word = 0, byte_count = 0, word_base = 0, area_end = 16'h00ff;
    logic [PORTS-1:0] settings_ok = 4'hf, port_reset = 0, rx_valid = 0, rx_end = 0;
    logic [PORTS-1:0] rx_ready, rx_complete, tx_enabled;
    logic [PORTS-1:0][7:0] rx_byte = '0;
    logic [PORTS-1:0][15:0] rx_count;
    logic [7:0] node_number = 8'h37, tx_char;
    logic [15:0] dst_addr, dst_wdata, src_addr, src_rdata;
    logic [1:0] dst_be, tx_port;
    logic dst_we, src_rd, tx_valid, tx_ready, op_done, operation_error_flag;
    logic [33:0] wq[$];
    int miscompares = 0, cmp_count = 0, cyc = 0;
    string e = "@37TX40294142*";
    spm_mover i_dut (.*);
    spm_far_model i_far (.*);
    always #20 clock = ~clock;
    // Record every destination write
    always @(posedge clock)
    begin
        if (dst_we)
            wq.push_back({dst_addr, dst_be, dst_wdata});
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            results();
        end
    end
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic feed(input int p, input int n, input logic [7:0] b);
        for (int i = 0; i < n; i++)
        begin
            rx_byte[p] = b + 8'(i);
            rx_valid[p] = 1'b1;
            while (!rx_ready[p])
                @(negedge clock);
            @(negedge clock);
        end
        rx_valid[p] = 1'b0;
        rx_end[p] = 1'b1;
        @(negedge clock);
        rx_end[p] = 1'b0;
        @(negedge clock);
    endtask
    task automatic op(input logic tx, input logic [15:0] c, input logic [15:0] n, input logic [15:0] a);
        ctrl_word = c;
        byte_count = n;
        word_base = a;
        wq.delete();
        start_tx = tx;
        start_rx = !tx;
        @(negedge clock);
        start_tx = 1'b0;
        start_rx = 1'b0;
        while (!op_done)
            @(negedge clock);
        @(negedge clock);
    endtask
    task automatic t_rx();
        feed(0, 3, 8'ha1);
        `CHK(rx_count[0], 16'h0003)
        `CHK(rx_complete[0], 1'b1)
        `CHK(wq.size(), 0)
        op(0, 16'h0000, 16'h0003, 16'h0010);
        `CHK(wq[0], {16'h0010, 2'b10, 16'ha1a1})
        `CHK(wq[1], {16'h0010, 2'b01, 16'ha2a2})
        `CHK(wq[2], {16'h0011, 2'b10, 16'ha3a3})
        `CHK({rx_count[0], rx_complete[0]}, 17'h0)
        $display("receive order 0 done");
    endtask
    task automatic t_short();
        feed(1, 2, 8'hb1);
        op(0, 16'h0011, 16'h0005, 16'h0020);
        `CHK(wq.size(), 2)
        `CHK(wq[0], {16'h0020, 2'b01, 16'hb1b1})
        `CHK(wq[1], {16'h0020, 2'b10, 16'hb2b2})
        $display("short receive order 1 done");
    endtask
    task automatic t_err();
        logic [15:0] ec[4] = '{16'h0020, 16'h0000, 16'h0000, 16'h0002};
        logic [15:0] en[4] = '{16'h0002, 16'h001a, 16'h0003, 16'h0002};
        logic [15:0] eb[4] = '{16'h0000, 16'h0000, 16'h00ff, 16'h0000};
        for (int k = 0; k < 4; k++)
        begin
            board_fitted = (k != 0);
            op(0, ec[k], en[k], eb[k]);
            `CHK({operation_error_flag, wq.size()}, {1'b1, 32'd0})
        end
        $display("error cases done");
    endtask
    task automatic t_zero();
        feed(0, 2, 8'hc1);
        op(0, 16'h0000, 16'h0000, 16'h0030);
        `CHK({rx_count[0], rx_complete[0], operation_error_flag, wq.size()}, 50'h0)
        feed(0, 1, 8'hd1);
        port_reset[0] = 1'b1;
        @(negedge clock);
        port_reset[0] = 1'b0;
        @(negedge clock);
        `CHK({rx_count[0], rx_complete[0]}, 17'h0)
        $display("clear and port reset done");
    endtask
    task automatic t_full();
        feed(3, 256, 8'h00);
        `CHK(rx_count[3], 16'h0256)
        // A full buffer must not offer ready again
        rx_valid[3] = 1'b1;
        repeat (8)
        begin
            @(negedge clock);
            `CHK(rx_ready[3], 1'b0)
        end
        rx_valid[3] = 1'b0;
        op(0, 16'h0030, 16'h0256, 16'h0000);
        `CHK(wq.size(), 256)
        `CHK(wq[255], {16'h007f, 2'b01, 16'hffff})
        `CHK(rx_count[3], 16'h0000)
        $display("full buffer done");
    endtask
    task automatic t_tx();
        // Count kept within the framed limit
        op(1, 16'h0010, 16'h0003, 16'h0040);
        repeat (10) @(negedge clock);
        `CHK(i_far.got.size(), 15)
        for (int i = 0; i < 14; i++)
            `CHK(i_far.got[i], 8'(e[i]))
        `CHK(i_far.got[14], 8'h0d)
        `CHK(tx_port, 2'h1)
        `CHK(tx_enabled[1], 1'b1)
        // Count beyond the framed limit is refused
        op(1, 16'h0010, 16'h0062, 16'h0040);
        `CHK({operation_error_flag, i_far.got.size()}, {1'b1, 32'd15})
        settings_ok = 4'hd;
        repeat (2) @(negedge clock);
        `CHK(tx_enabled[1], 1'b0)
        op(1, 16'h0010, 16'h0003, 16'h0040);
        `CHK({operation_error_flag, i_far.got.size()}, {1'b1, 32'd15})
        settings_ok = 4'hf;
        $display("framed transmit done");
    endtask
    // Main sequence
    initial
    begin
        repeat (3) @(negedge clock);
        arst_n = 1'b1;
        repeat (2) @(negedge clock);
        t_rx();
        t_short();
        t_err();
        t_zero();
        t_full();
        t_tx();
        results();
    end
endmodule // spm_mover_tb

// *** verilog/spm_byte_mem.sv ***
/*
 Receive byte store: 256 bytes per port, registered read.
 Assumes the owner never needs data in the cycle of its address.
*/
`timescale 1ns/100ps
module spm_byte_mem (
    input wire logic clock,
    spm_mem_if.store mem
);
    import spm_pkg::*;
    logic [7:0] cells [0:(1<<MEM_AW)-1];

    // One write and one registered read per clock
    always_ff @(posedge clock)
    begin
        if (mem.we)
        begin
            cells[mem.waddr] <= mem.wdata;
        end
        mem.rdata <= cells[mem.raddr];
    end
endmodule // spm_byte_mem

// *** verilog/spm_mem_if.sv ***
/*
 Carrier between the mover and its receive byte store.
 Assumes the store answers a read address one clock later.
*/
`timescale 1ns/100ps
interface spm_mem_if;
    logic we;
    logic [9:0] waddr;
    logic [7:0] wdata;
    logic [9:0] raddr;
    logic [7:0] rdata;
    modport owner (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** verilog/spm_mover.sv ***
/*
 Serial port byte mover: receive buffers, receive copy and framed transmit.
 Assumes synchronous inputs, one-cycle start pulses and source data
 valid one cycle after the read strobe is raised.
*/
`timescale 1ns/100ps
module spm_mover (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic start_rx,
    input wire logic start_tx,
    input wire logic [15:0] ctrl_word,
    input wire logic [15:0] byte_count,
    input wire logic [15:0] word_base,
    input wire logic [15:0] area_end,
    input wire logic board_fitted,
    input wire logic [spm_pkg::PORTS-1:0] settings_ok,
    input wire logic [7:0] node_number,
    input wire logic [spm_pkg::PORTS-1:0] port_reset,
    input wire logic [spm_pkg::PORTS-1:0][7:0] rx_byte,
    input wire logic [spm_pkg::PORTS-1:0] rx_valid,
    output logic [spm_pkg::PORTS-1:0] rx_ready,
    input wire logic [spm_pkg::PORTS-1:0] rx_end,
    output logic [spm_pkg::PORTS-1:0] rx_complete,
    output logic [spm_pkg::PORTS-1:0][15:0] rx_count,
    output logic dst_we,
    output logic [1:0] dst_be,
    output logic [15:0] dst_addr,
    output logic [15:0] dst_wdata,
    output logic src_rd,
    output logic [15:0] src_addr,
    input wire logic [15:0] src_rdata,
    output logic [7:0] tx_char,
    output logic [1:0] tx_port,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [spm_pkg::PORTS-1:0] tx_enabled,
    output logic op_done,
    output logic operation_error_flag
);
    import spm_pkg::*;

    function automatic logic bcd_ok(input logic [15:0] v);
        return v[15:12] < 4'ha && v[11:8] < 4'ha && v[7:4] < 4'ha && v[3:0] < 4'ha;
    endfunction

    function automatic logic [13:0] bcd_to_bin(input logic [15:0] v);
        return 14'(v[15:12]) * 14'h03e8 + 14'(v[11:8]) * 14'h0064 + 14'(v[7:4]) * 14'h000a + 14'(v[3:0]);
    endfunction

    function automatic logic [15:0] bcd_inc(input logic [15:0] v);
        logic [15:0] r;
        logic carry;
        r = v;
        carry = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            if (carry)
            begin
                carry = (r[4*i +: 4] == 4'h9);
                r[4*i +: 4] = carry ? 4'h0 : r[4*i +: 4] + 4'h1;
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] hex_char(input logic [3:0] d);
        return (d < 4'ha) ? 8'h30 + {4'h0, d} : 8'h37 + {4'h0, d};
    endfunction

    spm_mem_if mif ();
    spm_byte_mem u_mem (
        .clock(clock),
        .mem(mif)
    );

    spm_state_t state;
    logic [1:0] op_sel;
    logic op_tx;
    logic op_lo_first;
    logic [8:0] op_req;
    logic [8:0] op_total;
    logic [8:0] op_idx;
    logic [15:0] op_base;
    logic [3:0] tx_ph;
    logic [7:0] tx_ci;
    logic [15:0] tx_word;
    logic [7:0] fcs;
    logic [7:0] buf1;
    logic [1:0] buf_cnt;
    logic [1:0] tok;
    logic [1:0] rdy_port;
    logic [PORTS-1:0][8:0] cnt;

    // Operand decode shared by both operations
    wire logic [3:0] sel_digit = ctrl_word[7:4];
    wire logic [3:0] order_digit = ctrl_word[3:0];
    wire logic [1:0] sel = sel_digit[1:0];
    wire logic ctrl_ok = ctrl_word[15:8] == 8'h00 && sel_digit < PORT_LIMIT && order_digit < ORDER_LIMIT;
    wire logic fitted = (sel < FIRST_BOARD_PORT) || board_fitted;
    wire logic [13:0] n_bin = bcd_to_bin(byte_count);
    wire logic [16:0] last_word = {1'b0, word_base} + 17'((n_bin + 14'h0001) >> 1) - 17'h00001;
    wire logic range_bad = n_bin != 14'h0000 && last_word > {1'b0, area_end};
    // missing board port and bad operands
    wire logic base_err = !ctrl_ok || !bcd_ok(byte_count) || !fitted || !settings_ok[sel] || range_bad;
    wire logic rx_err = base_err || n_bin > RX_MAX;
    wire logic tx_err = base_err || n_bin > TX_MAX || !tx_enabled[sel];
    wire logic idle = state == ST_IDLE;
    // nothing happens without a start in idle
    wire logic rx_take = idle && start_rx;
    wire logic tx_take = idle && !start_rx && start_tx;
    wire logic zero_clear = rx_take && !rx_err && n_bin == 14'h0000;
    wire logic rx_finish = state == ST_DONE && !op_tx;

    // port reset, zero count and end of read clear a port
    wire logic [PORTS-1:0] clr = port_reset | ({PORTS{zero_clear}} & (PORTS'(1) << sel))
        | ({PORTS{rx_finish}} & (PORTS'(1) << op_sel));
    wire logic [PORTS-1:0] acc = rx_valid & rx_ready;
    wire logic [PORTS-1:0] full;
    wire logic [PORTS-1:0] lock;
    wire logic [PORTS-1:0] tx_busy;
    wire logic [8:0] wr_base = clr[rdy_port] ? 9'h000 : cnt[rdy_port];

    // Byte store writes come from the single ready port
    assign mif.we = |acc;
    assign mif.waddr = {rdy_port, wr_base[7:0]};
    assign mif.wdata = rx_byte[rdy_port];
    assign mif.raddr = {op_sel, op_idx[7:0]};

    // Per-port full, read lock and transmit occupancy
    for (genvar p = 0; p < PORTS; p++)
    begin : g_port
        assign full[p] = cnt[p] >= BUF_FULL;
        assign lock[p] = (!idle && !op_tx && op_sel == 2'(p)) || (rx_take && sel == 2'(p));
        assign tx_busy[p] = ((!idle && op_tx) || buf_cnt != 2'h0) && tx_port == 2'(p);
    end

    // Receive buffer counters, completion flags and ready token
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt <= '0;
            rx_count <= '0;
            rx_complete <= '0;
            rx_ready <= '0;
            tok <= 2'h0;
            rdy_port <= 2'h0;
        end
        else
        begin
            tok <= tok + 2'h1;
            rdy_port <= tok;
            for (int p = 0; p < PORTS; p++)
            begin
                // Binary and BCD counts of stored bytes, cleared then counted
                cnt[p] <= (clr[p] ? 9'h000 : cnt[p]) + {8'h00, acc[p]};
                if (clr[p] || acc[p])
                begin
                    rx_count[p] <= acc[p] ? bcd_inc(clr[p] ? BCD_ZERO : rx_count[p]) : BCD_ZERO;
                end
                // set at end of reception wins over clear
                rx_complete[p] <= rx_end[p] | (rx_complete[p] & ~clr[p]);
                // refuse once 256 bytes are held
                rx_ready[p] <= tok == 2'(p) && !full[p] && !lock[p] && !clr[p];
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_enabled <= '0;
        end
        else
        begin
            for (int p = 0; p < PORTS; p++)
            begin
                tx_enabled[p] <= settings_ok[p] && (2'(p) < FIRST_BOARD_PORT || board_fitted) && !tx_busy[p];
            end
        end
    end

    // Frame character selection
    wire logic [7:0] data_byte = tx_ci[1] ? tx_word[7:0] : tx_word[15:8];
    wire logic [3:0] data_nib = tx_ci[0] ? data_byte[3:0] : data_byte[7:4];
    logic [7:0] cur_char;
    // node, header and check code around the payload
    always_comb
    begin
        case (tx_ph)
            PH_PREFIX: cur_char = CH_PREFIX;
            PH_NODE_HI: cur_char = hex_char(node_number[7:4]);
            PH_NODE_LO: cur_char = hex_char(node_number[3:0]);
            PH_HDR0: cur_char = CH_HDR0;
            PH_HDR1: cur_char = CH_HDR1;
            PH_DATA: cur_char = hex_char(data_nib);
            PH_FCS_HI: cur_char = hex_char(fcs[7:4]);
            PH_FCS_LO: cur_char = hex_char(fcs[3:0]);
            PH_TERM: cur_char = CH_TERM;
            PH_CR: cur_char = CH_CR;
            default: cur_char = CH_CR;
        endcase
    end

    wire logic push = state == ST_TX_CHAR && buf_cnt != 2'h2;
    wire logic pop = tx_valid && tx_ready;
    wire logic last_char = {2'h0, tx_ci} + 10'h001 == {op_total, 1'b0};
    wire logic [8:0] rx_avail = cnt[op_sel] < op_req ? cnt[op_sel] : op_req;

    // Operation sequencer
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= ST_IDLE;
            op_sel <= 2'h0;
            op_tx <= 1'b0;
            op_lo_first <= 1'b0;
            op_req <= 9'h000;
            op_total <= 9'h000;
            op_idx <= 9'h000;
            op_base <= 16'h0000;
            tx_ph <= PH_PREFIX;
            tx_ci <= 8'h00;
            tx_word <= 16'h0000;
            fcs <= 8'h00;
            tx_port <= 2'h0;
            dst_we <= 1'b0;
            dst_be <= 2'h0;
            dst_addr <= 16'h0000;
            dst_wdata <= 16'h0000;
            src_rd <= 1'b0;
            src_addr <= 16'h0000;
            op_done <= 1'b0;
            operation_error_flag <= 1'b0;
        end
        else
        begin
            dst_we <= 1'b0;
            src_rd <= 1'b0;
            op_done <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    op_sel <= sel;
                    op_lo_first <= order_digit[0];
                    op_req <= n_bin[8:0];
                    op_base <= word_base;
                    op_idx <= 9'h000;
                    tx_ph <= PH_PREFIX;
                    tx_ci <= 8'h00;
                    fcs <= 8'h00;
                    if (rx_take)
                    begin
                        op_tx <= 1'b0;
                        operation_error_flag <= rx_err;
                        op_done <= rx_err || zero_clear;
                        state <= (rx_err || zero_clear) ? ST_IDLE : ST_RX_GO;
                    end
                    else if (tx_take)
                    begin
                        op_tx <= 1'b1;
                        operation_error_flag <= tx_err;
                        op_done <= tx_err;
                        op_total <= n_bin[8:0];
                        state <= tx_err ? ST_IDLE : ST_TX_CHAR;
                        if (!tx_err)
                        begin
                            tx_port <= sel;
                        end
                    end
                end
                // copy only what the port holds
                ST_RX_GO:
                begin
                    op_total <= rx_avail;
                    state <= rx_avail == 9'h000 ? ST_DONE : ST_RX_RD;
                end
                ST_RX_RD:
                begin
                    state <= ST_RX_WR;
                end
                ST_RX_WR:
                begin
                    // order 0 packs earlier byte high, order 1 swaps
                    // byte enable leaves the other half untouched
                    dst_we <= 1'b1;
                    dst_be <= (op_idx[0] ^ op_lo_first) ? 2'b01 : 2'b10;
                    dst_addr <= op_base + {8'h00, op_idx[8:1]};
                    dst_wdata <= {mif.rdata, mif.rdata};
                    op_idx <= op_idx + 9'h001;
                    state <= (op_idx + 9'h001 == op_total) ? ST_DONE : ST_RX_RD;
                end
                ST_TX_FETCH:
                begin
                    src_rd <= 1'b1;
                    src_addr <= op_base + {10'h000, tx_ci[7:2]};
                    state <= ST_TX_WAIT;
                end
                ST_TX_WAIT:
                begin
                    if (!src_rd)
                    begin
                        tx_word <= src_rdata;
                        state <= ST_TX_CHAR;
                    end
                end
                // payload bytes leave as hex ASCII
                ST_TX_CHAR:
                begin
                    if (push)
                    begin
                        if (tx_ph < PH_FCS_HI)
                        begin
                            fcs <= fcs ^ cur_char;
                        end
                        case (tx_ph)
                            PH_HDR1:
                            begin
                                tx_ph <= op_total == 9'h000 ? PH_FCS_HI : PH_DATA;
                                state <= op_total == 9'h000 ? ST_TX_CHAR : ST_TX_FETCH;
                            end
                            PH_DATA:
                            begin
                                tx_ci <= tx_ci + 8'h01;
                                if (last_char)
                                begin
                                    tx_ph <= PH_FCS_HI;
                                end
                                else if (tx_ci[1:0] == 2'h3)
                                begin
                                    state <= ST_TX_FETCH;
                                end
                            end
                            PH_CR:
                            begin
                                state <= ST_DONE;
                            end
                            default:
                            begin
                                tx_ph <= tx_ph + 4'h1;
                            end
                        endcase
                    end
                end
                ST_DONE:
                begin
                    op_done <= 1'b1;
                    state <= ST_IDLE;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Two-entry character buffer toward the transmitter
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_char <= 8'h00;
            buf1 <= 8'h00;
            buf_cnt <= 2'h0;
            tx_valid <= 1'b0;
        end
        else
        begin
            if (push && (buf_cnt == 2'h0 || (pop && buf_cnt == 2'h1)))
            begin
                tx_char <= cur_char;
            end
            else if (pop)
            begin
                tx_char <= buf1;
            end
            if (push && (buf_cnt == 2'h1 + {1'b0, pop}) && buf_cnt != 2'h0)
            begin
                buf1 <= cur_char;
            end
            buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
            tx_valid <= (buf_cnt + {1'b0, push} - {1'b0, pop}) != 2'h0;
        end
    end

    sequence s_rx_bad_port;
        rx_take && !fitted;
    endsequence

    sequence s_tx_go;
        tx_take && !tx_err;
    endsequence

    chk_idle_quiet: assert property (@(posedge clock) disable iff (!arst_n)
        idle && !start_rx && !start_tx |=> !dst_we && !src_rd && idle)
        else $error("activity without a start");
    chk_full_refuse: assert property (@(posedge clock) disable iff (!arst_n)
        (full & rx_ready) == '0)
        else $error("ready while buffer full");
    // missing board gives error and no transfer
    chk_board_error: assert property (@(posedge clock) disable iff (!arst_n)
        s_rx_bad_port |=> operation_error_flag && op_done && idle ##1 !dst_we)
        else $error("missing board not flagged");
    chk_range_error: assert property (@(posedge clock) disable iff (!arst_n)
        rx_take && range_bad |=> operation_error_flag && idle)
        else $error("range overrun not flagged");
    // completed flag cleared after the read
    chk_read_clears: assert property (@(posedge clock) disable iff (!arst_n)
        rx_finish && !rx_end[op_sel] |=> !rx_complete[$past(op_sel)] && rx_count[$past(op_sel)] == BCD_ZERO)
        else $error("port not cleared after read");
    // order 0 even byte lands high
    chk_pack_high: assert property (@(posedge clock) disable iff (!arst_n)
        state == ST_RX_WR && !op_lo_first && !op_idx[0] |=> dst_we && dst_be == 2'b10)
        else $error("order 0 packing wrong");
    // order 1 even byte lands low
    chk_pack_low: assert property (@(posedge clock) disable iff (!arst_n)
        state == ST_RX_WR && op_lo_first && !op_idx[0] |=> dst_we && dst_be == 2'b01)
        else $error("order 1 packing wrong");
    // never more than requested or 256
    chk_rx_bound: assert property (@(posedge clock) disable iff (!arst_n)
        state == ST_RX_RD |-> op_total <= op_req && op_total <= BUF_FULL && op_idx < op_total)
        else $error("receive count out of bounds");
    // frame opens with the prefix character
    chk_frame_prefix: assert property (@(posedge clock) disable iff (!arst_n)
        s_tx_go |-> ##[1:3] (tx_valid && tx_char == CH_PREFIX))
        else $error("frame prefix missing");
    chk_tx_disabled: assert property (@(posedge clock) disable iff (!arst_n)
        s_tx_go |=> ##1 !tx_enabled[tx_port])
        else $error("transmit enabled while busy");
endmodule // spm_mover

// *** verilog/spm_pkg.sv ***
/*
 Shared constants and types for the serial port byte mover.
 Assumes one 25 MHz clock and an active-low asynchronous reset.
*/
package spm_pkg;
    localparam int PORTS = 4;
    localparam int MEM_AW = 10;
    localparam logic [8:0] BUF_FULL = 9'h100;
    localparam logic [13:0] RX_MAX = 14'h0100;
    localparam logic [13:0] TX_MAX = 14'h003d;
    localparam logic [1:0] FIRST_BOARD_PORT = 2'h2;
    localparam logic [3:0] PORT_LIMIT = 4'h4;
    localparam logic [3:0] ORDER_LIMIT = 4'h2;
    localparam logic [15:0] BCD_ZERO = 16'h0000;
    localparam logic [7:0] CH_PREFIX = 8'h40;
    localparam logic [7:0] CH_HDR0 = 8'h54;
    localparam logic [7:0] CH_HDR1 = 8'h58;
    localparam logic [7:0] CH_TERM = 8'h2a;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [3:0] PH_PREFIX = 4'h0;
    localparam logic [3:0] PH_NODE_HI = 4'h1;
    localparam logic [3:0] PH_NODE_LO = 4'h2;
    localparam logic [3:0] PH_HDR0 = 4'h3;
    localparam logic [3:0] PH_HDR1 = 4'h4;
    localparam logic [3:0] PH_DATA = 4'h5;
    localparam logic [3:0] PH_FCS_HI = 4'h6;
    localparam logic [3:0] PH_FCS_LO = 4'h7;
    localparam logic [3:0] PH_TERM = 4'h8;
    localparam logic [3:0] PH_CR = 4'h9;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX_GO = 3'b001,
        ST_RX_RD = 3'b010,
        ST_RX_WR = 3'b011,
        ST_TX_FETCH = 3'b100,
        ST_TX_WAIT = 3'b101,
        ST_TX_CHAR = 3'b110,
        ST_DONE = 3'b111
    } spm_state_t;
endpackage
